// file: rtl/pdl_ctrl.sv
/*
  Phase comparator, dividers, lock detector and serial register port.
  Assumes serial pins, reference and RF inputs are asynchronous and
  far slower than the 200 MHz clock; edges are found by sampling.
*/
// Overview of operation
// - Up enable clear masks every up pulse from the charge pump.
// - Down enable clear masks every down pulse from the charge pump.
// - Both enables and both force bits clear puts charge pump in high impedance, rest keeps running.
// - Force bits hold the charge pump sourcing or sinking continuously.
// - Reference buffer bit selects high gain or high frequency mode.
// - Reference divider is 14 bits, dividing by 1 to 16383.
// - RF divider spans 20..524283 fractional, 16..524287 integer.
// - Lock detector and counters run only while enabled.
// - Status register bit reads one when locked.
// - Lock indication can drive the shared output pin, high when locked.
// - Timer runs only when enabled; train bit starts window calibration.
// - Both edges inside one window increment the lock counter.
// - Lock is declared at threshold and held while count stays there.
// - A missed window clears the counter and unlocks at once.
// - Window length comes from timer speed and divide fields, or from the trained value once training completes.
// - Pin select value one routes lock to the shared pin.
// - During a serial read the shared pin carries readback data unless the pin select always bit is set.
`timescale 1ns/1ps
module pdl_ctrl
  import pdl_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Serial port pins
  input wire pdl_ser_t i_ser,
  // Divider inputs
  input wire logic i_ref_in,
  input wire logic i_rf_in,
  input wire logic [18:0] i_n_ratio,
  input wire logic i_frac_mode,
  // Charge pump and reference buffer
  output pdl_cp_t o_cp,
  output logic o_ref_high_freq,
  // Shared lock and readback pin
  output logic o_lock_or_readback_pin
);

  function automatic logic [WIN_W-1:0] win_cycles(input logic [1:0] spd,
                                                  input logic [2:0] dv);
    int c;
    c = LD_WIN_PS[spd][dv] / CLK_PERIOD_PS;
    if (c < 1) begin
      c = 1;
    end
    return WIN_W'(c);
  endfunction

  function automatic logic rise(input logic now, input logic prev);
    return now & ~prev;
  endfunction

  // Input synchronisers
  logic [4:0] s1_reg;
  logic [4:0] s2_reg;
  logic [4:0] s3_reg;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s1_reg <= 5'h00;
      s2_reg <= 5'h00;
      s3_reg <= 5'h00;
    end else begin
      s1_reg <= {i_rf_in, i_ref_in, i_ser.sen, i_ser.sdi, i_ser.sck};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  logic sck_rise;
  logic sck_fall;
  logic sen_fall;
  logic ref_edge;
  logic rf_edge;
  assign sck_rise = rise(s2_reg[0], s3_reg[0]);
  assign sck_fall = rise(s3_reg[0], s2_reg[0]);
  assign sen_fall = rise(s3_reg[2], s2_reg[2]);
  assign ref_edge = rise(s2_reg[3], s3_reg[3]);
  assign rf_edge = rise(s2_reg[4], s3_reg[4]);

  // Registers
  logic [23:0] ref_div_reg;
  logic [23:0] ld_cfg_reg;
  logic [23:0] ref_buf_reg;
  logic [23:0] pd_ctl_reg;
  logic [23:0] pin_sel_reg;
  logic lock_reg;

  // Serial port
  logic [30:0] sh_reg;
  logic [4:0] bit_cnt_reg;
  logic [23:0] rd_sh_reg;
  logic sdo_reg;
  logic rd_flag_reg;
  logic wr_commit;
  logic [5:0] hdr_addr;
  assign hdr_addr = sh_reg[5:0];
  assign wr_commit = sen_fall && bit_cnt_reg == SER_FRAME_BITS && !sh_reg[30];

  function automatic logic [23:0] rd_mux(input logic [5:0] a);
    unique case (a)
      ADDR_REF_DIV: return ref_div_reg;
      ADDR_LD_CFG: return ld_cfg_reg;
      ADDR_REF_BUF: return ref_buf_reg;
      ADDR_PD_CTL: return pd_ctl_reg;
      ADDR_PIN_SEL: return pin_sel_reg;
      ADDR_LD_STAT: return 24'(lock_reg) << STAT_LOCK_BIT;
      default: return 24'h000000;
    endcase
  endfunction

  // Read flag kept apart: it walks up the shift register as data arrives
  always_ff @(posedge i_clk) begin
    if (i_rst || !s2_reg[2]) begin
      sh_reg <= 31'h00000000;
      bit_cnt_reg <= 5'h00;
      rd_flag_reg <= 1'b0;
    end else if (sck_rise && bit_cnt_reg != SER_FRAME_BITS) begin
      sh_reg <= {sh_reg[29:0], s2_reg[1]};
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
      if (bit_cnt_reg == 5'h00) begin
        rd_flag_reg <= s2_reg[1];
      end
    end
  end

  // Read data leaves on falling clock, MSB first
  logic reading;
  assign reading = s2_reg[2] && bit_cnt_reg >= SER_HDR_BITS && rd_flag_reg;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rd_sh_reg <= 24'h000000;
      sdo_reg <= 1'b0;
    end else if (sck_rise && bit_cnt_reg == SER_HDR_BITS - 5'h01) begin
      rd_sh_reg <= rd_mux({sh_reg[4:0], s2_reg[1]});
    end else if (reading && sck_fall) begin
      sdo_reg <= rd_sh_reg[23];
      rd_sh_reg <= {rd_sh_reg[22:0], 1'b0};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ref_div_reg <= RST_REF_DIV;
      ld_cfg_reg <= RST_LD_CFG;
      ref_buf_reg <= RST_REF_BUF;
      pd_ctl_reg <= RST_PD_CTL;
      pin_sel_reg <= RST_PIN_SEL;
    end else if (wr_commit) begin
      unique case (sh_reg[29:24])
        ADDR_REF_DIV: ref_div_reg <= sh_reg[23:0];
        ADDR_LD_CFG: ld_cfg_reg <= sh_reg[23:0];
        ADDR_REF_BUF: ref_buf_reg <= sh_reg[23:0];
        ADDR_PD_CTL: pd_ctl_reg <= sh_reg[23:0];
        ADDR_PIN_SEL: pin_sel_reg <= sh_reg[23:0];
        default: ;
      endcase
    end
  end

  logic ld_en;
  logic tmr_en;
  logic train;
  logic [2:0] ld_thr;
  assign ld_en = ld_cfg_reg[LD_EN_BIT];
  assign tmr_en = ld_cfg_reg[LD_TMR_BIT];
  assign train = ld_cfg_reg[LD_TRAIN_BIT];
  assign ld_thr = ld_cfg_reg[LD_THR_LSB +: 3];

  // Reference divider; a zero setting behaves as one
  logic [13:0] r_cnt_reg;
  logic [13:0] r_val;
  logic ref_pulse;
  assign r_val = ref_div_reg[13:0] == 14'h0000 ? 14'h0001 : ref_div_reg[13:0];
  assign ref_pulse = ref_edge && r_cnt_reg >= r_val - 14'h0001;
  always_ff @(posedge i_clk) begin
    if (i_rst || ref_pulse) begin
      r_cnt_reg <= 14'h0000;
    end else if (ref_edge) begin
      r_cnt_reg <= r_cnt_reg + 14'h0001;
    end
  end

  // RF divider, ratio clamped to the legal range of the mode
  logic [18:0] n_cnt_reg;
  logic [18:0] n_val;
  logic rf_pulse;
  always_comb begin
    n_val = i_n_ratio;
    if (i_frac_mode) begin
      if (n_val < N_MIN_FRAC) n_val = N_MIN_FRAC;
      if (n_val > N_MAX_FRAC) n_val = N_MAX_FRAC;
    end else if (n_val < N_MIN_INT) begin
      n_val = N_MIN_INT;
    end
  end
  assign rf_pulse = rf_edge && n_cnt_reg >= n_val - 19'h00001;
  always_ff @(posedge i_clk) begin
    if (i_rst || rf_pulse) begin
      n_cnt_reg <= 19'h00000;
    end else if (rf_edge) begin
      n_cnt_reg <= n_cnt_reg + 19'h00001;
    end
  end

  // Phase comparator and charge pump drive
  logic up_q_reg;
  logic dn_q_reg;
  logic up_set;
  logic dn_set;
  assign up_set = up_q_reg | ref_pulse;
  assign dn_set = dn_q_reg | rf_pulse;
  always_ff @(posedge i_clk) begin
    if (i_rst || (up_set && dn_set)) begin
      up_q_reg <= 1'b0;
      dn_q_reg <= 1'b0;
    end else begin
      up_q_reg <= up_set;
      dn_q_reg <= dn_set;
    end
  end

  logic up_en;
  logic dn_en;
  logic frc_up;
  logic frc_dn;
  assign up_en = pd_ctl_reg[PD_UP_EN_BIT];
  assign dn_en = pd_ctl_reg[PD_DN_EN_BIT];
  assign frc_up = pd_ctl_reg[PD_FRC_UP_BIT];
  assign frc_dn = pd_ctl_reg[PD_FRC_DN_BIT];
  // Forcing overrides the masks so the tuning range ends can be reached
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_cp <= '0;
      o_ref_high_freq <= 1'b0;
    end else begin
      o_cp.up <= frc_up | (up_en & up_q_reg);
      o_cp.dn <= frc_dn | (dn_en & dn_q_reg);
      o_cp.hiz <= !up_en && !dn_en && !frc_up && !frc_dn;
      o_ref_high_freq <= ref_buf_reg[REF_BUF_HF_BIT];
    end
  end

  // Training: half of one measured comparison period
  pdl_tr_st_t tr_st_reg;
  logic train_q_reg;
  logic trained_reg;
  logic [WIN_W:0] per_cnt_reg;
  logic [WIN_W-1:0] tr_win_reg;
  always_ff @(posedge i_clk) begin
    if (i_rst || !train || !tmr_en) begin
      tr_st_reg <= TR_IDLE;
      trained_reg <= 1'b0;
      per_cnt_reg <= '0;
      tr_win_reg <= '0;
    end else begin
      unique case (tr_st_reg)
        TR_IDLE: if (!train_q_reg) tr_st_reg <= TR_ARM;
        TR_ARM: if (ref_pulse) begin
          tr_st_reg <= TR_MEAS;
          per_cnt_reg <= '0;
        end
        TR_MEAS: if (ref_pulse) begin
          tr_win_reg <= per_cnt_reg[WIN_W:1] == '0 ? WIN_W'(1) :
                        per_cnt_reg[WIN_W:1];
          trained_reg <= 1'b1;
          tr_st_reg <= TR_IDLE;
        end else if (!(&per_cnt_reg)) begin
          per_cnt_reg <= per_cnt_reg + 1'b1;
        end
      endcase
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) train_q_reg <= 1'b0;
    else train_q_reg <= train && tmr_en;
  end

  logic [WIN_W-1:0] win_len;
  assign win_len = trained_reg ? tr_win_reg :
                   win_cycles(ld_cfg_reg[LD_SPD_LSB +: 2],
                              ld_cfg_reg[LD_DIV_LSB +: 3]);

  // Lock window tracking
  pdl_ld_st_t ld_st_reg;
  logic [WIN_W-1:0] win_cnt_reg;
  logic [2:0] hit_cnt_reg;
  logic hit;
  logic miss;
  always_comb begin
    hit = 1'b0;
    miss = 1'b0;
    unique case (ld_st_reg)
      LD_IDLE: hit = ref_pulse && rf_pulse;
      LD_WAIT_RF: begin
        hit = rf_pulse && win_cnt_reg < win_len;
        miss = !hit && (ref_pulse || win_cnt_reg >= win_len);
      end
      LD_WAIT_REF: begin
        hit = ref_pulse && win_cnt_reg < win_len;
        miss = !hit && (rf_pulse || win_cnt_reg >= win_len);
      end
      default: ;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || !ld_en || !tmr_en) begin
      ld_st_reg <= LD_IDLE;
      win_cnt_reg <= '0;
    end else if (ld_st_reg == LD_IDLE) begin
      win_cnt_reg <= WIN_W'(1);
      if (ref_pulse && !rf_pulse) ld_st_reg <= LD_WAIT_RF;
      else if (rf_pulse && !ref_pulse) ld_st_reg <= LD_WAIT_REF;
    end else if (hit || miss) begin
      ld_st_reg <= LD_IDLE;
    end else begin
      win_cnt_reg <= win_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || !ld_en) begin
      hit_cnt_reg <= 3'h0;
      lock_reg <= 1'b0;
    end else if (miss) begin
      hit_cnt_reg <= 3'h0;
      lock_reg <= 1'b0;
    end else if (hit) begin
      if (hit_cnt_reg != 3'h7) hit_cnt_reg <= hit_cnt_reg + 3'h1;
      if (hit_cnt_reg + 3'h1 >= ld_thr || hit_cnt_reg == 3'h7) begin
        lock_reg <= 1'b1;
      end
    end
  end

  // Shared pin: readback wins during a read unless lock is pinned there
  logic pin_lock;
  assign pin_lock = pin_sel_reg[4:0] == PIN_SEL_LOCK ||
                    pin_sel_reg[PIN_ALWAYS_BIT];
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_lock_or_readback_pin <= 1'b0;
    end else if (reading && !pin_sel_reg[PIN_ALWAYS_BIT]) begin
      o_lock_or_readback_pin <= sdo_reg;
    end else begin
      o_lock_or_readback_pin <= pin_lock & lock_reg;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_hit_at_thr;
    hit && !miss && hit_cnt_reg + 3'h1 >= ld_thr && ld_en;
  endsequence
  property p_up_mask;
    !up_en && !frc_up |=> !o_cp.up;
  endproperty
  a_up_mask: assert property (p_up_mask) else $error("up not masked");
  property p_dn_mask;
    !dn_en && !frc_dn |=> !o_cp.dn;
  endproperty
  a_dn_mask: assert property (p_dn_mask) else $error("dn not masked");
  property p_hiz;
    !up_en && !dn_en && !frc_up && !frc_dn |=> o_cp.hiz && !o_cp.up;
  endproperty
  a_hiz: assert property (p_hiz) else $error("pump not tristated");
  property p_force;
    frc_up && frc_dn |=> o_cp.up && o_cp.dn && !o_cp.hiz;
  endproperty
  a_force: assert property (p_force) else $error("force ignored");
  property p_disabled;
    !ld_en |=> !lock_reg && hit_cnt_reg == 3'h0;
  endproperty
  a_disabled: assert property (p_disabled) else $error("lock kept");
  property p_lock_set;
    s_hit_at_thr |=> lock_reg;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("no lock");
  property p_miss;
    miss |=> !lock_reg && hit_cnt_reg == 3'h0;
  endproperty
  a_miss: assert property (p_miss) else $error("miss kept lock");
  property p_pin;
    !reading && pin_sel_reg[4:0] == PIN_SEL_LOCK ##1 !reading
      |-> o_lock_or_readback_pin == $past(lock_reg);
  endproperty
  a_pin: assert property (p_pin) else $error("pin not lock");
  property p_win;
    ld_st_reg == LD_WAIT_RF && win_cnt_reg >= win_len && !rf_pulse
      |=> ld_st_reg == LD_IDLE && !lock_reg;
  endproperty
  a_win: assert property (p_win) else $error("window overrun");

endmodule

// file: rtl/pdl_pkg.sv
/*
  Package for the phase comparator and lock detect control block.
  Holds register offsets, field positions, reset values, lock window
  figures and the packed carriers. Assumes a 200 MHz system clock.
*/
package pdl_pkg;

  // Clock
  localparam int CLK_PERIOD_PS = 5000;

  // Register offsets (6-bit serial address)
  localparam logic [5:0] ADDR_REF_DIV = 6'h02;
  localparam logic [5:0] ADDR_LD_CFG = 6'h07;
  localparam logic [5:0] ADDR_REF_BUF = 6'h08;
  localparam logic [5:0] ADDR_PD_CTL = 6'h0b;
  localparam logic [5:0] ADDR_PIN_SEL = 6'h0f;
  localparam logic [5:0] ADDR_LD_STAT = 6'h12;

  // Field positions
  localparam int LD_THR_LSB = 0;
  localparam int LD_DIV_LSB = 5;
  localparam int LD_SPD_LSB = 8;
  localparam int LD_EN_BIT = 11;
  localparam int LD_TMR_BIT = 14;
  localparam int LD_TRAIN_BIT = 20;
  localparam int REF_BUF_HF_BIT = 21;
  localparam int PD_UP_EN_BIT = 5;
  localparam int PD_DN_EN_BIT = 6;
  localparam int PD_FRC_UP_BIT = 9;
  localparam int PD_FRC_DN_BIT = 10;
  localparam int PIN_ALWAYS_BIT = 6;
  localparam int STAT_LOCK_BIT = 1;
  localparam logic [4:0] PIN_SEL_LOCK = 5'h01;

  // Reset values
  localparam logic [23:0] RST_REF_DIV = 24'h000001;
  localparam logic [23:0] RST_LD_CFG = 24'h000000;
  localparam logic [23:0] RST_REF_BUF = 24'h000000;
  localparam logic [23:0] RST_PD_CTL = 24'h000060;
  localparam logic [23:0] RST_PIN_SEL = 24'h000000;

  // Serial frame: read flag, 6 address bits, 24 data bits
  localparam logic [4:0] SER_HDR_BITS = 5'h07;
  localparam logic [4:0] SER_FRAME_BITS = 5'h1f;

  // Divider ranges
  localparam logic [18:0] N_MAX_INT = 19'h7ffff;
  localparam logic [18:0] N_MIN_INT = 19'h00010;
  localparam logic [18:0] N_MAX_FRAC = 19'h7fffb;
  localparam logic [18:0] N_MIN_FRAC = 19'h00014;

  // Nominal lock window in ps, [timer speed][timer divide]
  localparam int LD_WIN_PS [0:3][0:7] = '{
    '{6500, 8000, 11000, 17000, 29000, 53000, 100000, 195000},
    '{7000, 8900, 12800, 21000, 36000, 68000, 130000, 255000},
    '{7100, 9200, 13300, 22000, 38000, 72000, 138000, 272000},
    '{7600, 10200, 15400, 26000, 47000, 88000, 172000, 338000}};
  localparam int WIN_W = 10;

  typedef struct packed {
    logic up;
    logic dn;
    logic hiz;
  } pdl_cp_t;

  typedef struct packed {
    logic sck;
    logic sdi;
    logic sen;
  } pdl_ser_t;

  typedef enum logic [1:0] {LD_IDLE, LD_WAIT_RF, LD_WAIT_REF} pdl_ld_st_t;
  typedef enum logic [1:0] {TR_IDLE, TR_ARM, TR_MEAS} pdl_tr_st_t;

endpackage

// file: verification/pdl_host_model.sv
/*
  Host model: drives the serial register port of the lock control block.
  Assumes the 200 MHz clock and the block's pin for readback data.
*/
`timescale 1ns/1ps
module pdl_host_model
  import pdl_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Shared pin and serial pins
  input wire logic i_pin,
  output pdl_ser_t o_ser
);
  initial o_ser = '0;
  // Four clocks per phase leaves margin over the two flop synchroniser
  task automatic frame(input logic rd, input logic [5:0] a,
                       input logic [23:0] d, output logic [23:0] q);
    logic [30:0] b;
    b = {rd, a, d};
    q = '0;
    o_ser.sen <= 1'b1;
    for (int i = 0; i < 31; i++) begin
      o_ser.sck <= 1'b0;
      o_ser.sdi <= b[30 - i];
      repeat (4) @(posedge i_clk);
      o_ser.sck <= 1'b1;
      repeat (4) @(posedge i_clk);
      // Readback bit settles four clocks after the fall; take it late
      if (rd && i >= 7) q = {q[22:0], i_pin};
    end
    o_ser.sck <= 1'b0;
    // Released data line shows the inverse, not a stale copy
    o_ser.sdi <= ~o_ser.sdi;
    repeat (4) @(posedge i_clk);
    o_ser.sen <= 1'b0;
    repeat (8) @(posedge i_clk);
  endtask
endmodule

// file: verification/tb.sv
/*
  Testbench for the lock control block: register access, charge pump
  masks and forces, dividers and lock detection. Assumes the host model.
*/
`timescale 1ns/1ps
module tb;
  import pdl_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_ref_in = 1'b0;
  logic i_rf_in = 1'b0;
  logic [18:0] i_n_ratio = 19'h00010;
  logic i_frac_mode = 1'b0;
  logic ref_run = 1'b0;
  logic rf_run = 1'b0;
  logic up_seen = 1'b0;
  logic dn_seen = 1'b0;
  pdl_ser_t ser;
  pdl_cp_t o_cp;
  logic o_ref_high_freq;
  logic o_lock_or_readback_pin;
  logic [23:0] q;
  int miscompares = 0;
  int checks = 0;
  int ref_cnt = 0;
  int rf_cnt = 0;

  always #2.5 i_clk = ~i_clk;

  pdl_ctrl u_pdl_ctrl (.i_clk(i_clk), .i_rst(i_rst), .i_ser(ser),
    .i_ref_in(i_ref_in), .i_rf_in(i_rf_in), .i_n_ratio(i_n_ratio),
    .i_frac_mode(i_frac_mode), .o_cp(o_cp),
    .o_ref_high_freq(o_ref_high_freq),
    .o_lock_or_readback_pin(o_lock_or_readback_pin));
  pdl_host_model u_pdl_host_model (.i_clk(i_clk),
    .i_pin(o_lock_or_readback_pin), .o_ser(ser));

  // Reference period 96 clocks; 16 RF edges also take 96 clocks
  always @(posedge i_clk) begin
    ref_cnt <= (ref_cnt == 47) ? 0 : ref_cnt + 1;
    if (ref_run && ref_cnt == 47) i_ref_in <= ~i_ref_in;
    rf_cnt <= (rf_cnt == 2) ? 0 : rf_cnt + 1;
    if (rf_run && rf_cnt == 2) i_rf_in <= ~i_rf_in;
    if (o_cp.up === 1'b1) up_seen <= 1'b1;
    if (o_cp.dn === 1'b1) dn_seen <= 1'b1;
  end

  task automatic check(input string what, input logic [23:0] exp,
                       input logic [23:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    u_pdl_host_model.frame(1'b0, a, d, q);
  endtask
  task automatic rd(input logic [5:0] a);
    u_pdl_host_model.frame(1'b1, a, 24'h000000, q);
  endtask
  // Bounded wait for the shared pin to reach a level
  task automatic wait_pin(input logic v, input int n);
    for (int i = 0; i < n && o_lock_or_readback_pin !== v; i++)
      @(posedge i_clk);
  endtask
  task automatic pin(input logic v);
    check("pin", {23'h0, v}, {23'h0, o_lock_or_readback_pin});
  endtask
  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge i_clk);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
    rd(ADDR_REF_DIV);
    check("ref_div", RST_REF_DIV, q);
    rd(ADDR_LD_CFG);
    check("ld_cfg", RST_LD_CFG, q);
    rd(ADDR_PD_CTL);
    check("pd_ctl", RST_PD_CTL, q);
    rd(6'h3f);
    check("unmapped", 24'h000000, q);
    wr(ADDR_REF_BUF, 24'h200000);
    check("hf", 24'h000001, {23'h0, o_ref_high_freq});
    rd(ADDR_REF_BUF);
    check("ref_buf", 24'h200000, q);
    wr(ADDR_REF_BUF, 24'h000000);
    check("hf", 24'h000000, {23'h0, o_ref_high_freq});
    wr(ADDR_PD_CTL, 24'h000200);
    check("cp", 24'h000004, {21'h0, o_cp});
    wr(ADDR_PD_CTL, 24'h000400);
    check("cp", 24'h000002, {21'h0, o_cp});
    wr(ADDR_PD_CTL, 24'h000000);
    check("cp", 24'h000001, {21'h0, o_cp});
    wr(ADDR_PIN_SEL, 24'h000001);
    ref_run <= 1'b1;
    rf_run <= 1'b1;
    up_seen <= 1'b0;
    dn_seen <= 1'b0;
    repeat (300) @(posedge i_clk);
    pin(1'b0);
    // Enable, timer, slowest window of 67 clocks, threshold 3
    wr(ADDR_LD_CFG, 24'h004be3);
    repeat (150) @(posedge i_clk);
    pin(1'b0);
    wait_pin(1'b1, 800);
    pin(1'b1);
    rd(ADDR_LD_STAT);
    check("status", 24'h000002, q & 24'h000002);
    pin(1'b1);
    check("hiz", 24'h000000, {22'h0, up_seen, dn_seen});
    wr(ADDR_PD_CTL, 24'h000040);
    up_seen <= 1'b0;
    repeat (500) @(posedge i_clk);
    check("up_seen", 24'h000000, {23'h0, up_seen});
    wr(ADDR_PD_CTL, 24'h000020);
    dn_seen <= 1'b0;
    repeat (500) @(posedge i_clk);
    check("dn_seen", 24'h000000, {23'h0, dn_seen});
    wr(ADDR_REF_DIV, 24'h000002);
    wait_pin(1'b0, 600);
    pin(1'b0);
    i_n_ratio <= 19'h00020;
    wait_pin(1'b1, 1500);
    pin(1'b1);
    // Ratio 5 is below range; it must act as 16
    i_n_ratio <= 19'h00005;
    wait_pin(1'b0, 600);
    pin(1'b0);
    wr(ADDR_REF_DIV, 24'h000001);
    wait_pin(1'b1, 1500);
    pin(1'b1);
    rf_run <= 1'b0;
    wait_pin(1'b0, 300);
    pin(1'b0);
    rd(ADDR_LD_STAT);
    check("status", 24'h000000, q & 24'h000002);
    rf_run <= 1'b1;
    wait_pin(1'b1, 1500);
    wr(ADDR_LD_CFG, 24'h0043e3);
    pin(1'b0);
    repeat (400) @(posedge i_clk);
    pin(1'b0);
    wr(ADDR_LD_CFG, 24'h104be3);
    wr(ADDR_LD_CFG, 24'h004be3);
    wr(ADDR_LD_CFG, 24'h104be3);
    wait_pin(1'b1, 2000);
    pin(1'b1);
    tally_and_finish();
  end
endmodule
